// >>> inc/ssd_pkg.sv
// ssd_pkg: constants and types for the signed short divide unit
// assumes: 32-bit integer datapath, one clock domain
package ssd_pkg;
    // ----------------------------------------------------------------
    // widths and values
    // ----------------------------------------------------------------
    localparam int          SSD_W        = 32;
    localparam int          SSD_CNT_W    = 6;
    localparam logic [5:0]  SSD_STEPS    = 6'h20;
    localparam logic [31:0] SSD_MOST_NEG = 32'h8000_0000;
    localparam logic [31:0] SSD_MINUS1   = 32'hffff_ffff;
    localparam logic [31:0] SSD_ZERO     = 32'h0000_0000;
    // condition field bit positions: lt, gt, eq, summary overflow copy
    localparam int          SSD_CF_LT    = 3;
    localparam int          SSD_CF_GT    = 2;
    localparam int          SSD_CF_EQ    = 1;
    localparam int          SSD_CF_SO    = 0;
    localparam logic [3:0]  SSD_CF_RST   = 4'h0;

    // ----------------------------------------------------------------
    // states
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        SSD_IDLE = 2'b00,
        SSD_RUN  = 2'b01,
        SSD_FIN  = 2'b10
    } ssd_state_e;
endpackage : ssd_pkg

// >>> design/ssd_udiv_step.sv
// ssd_udiv_step: one restoring step of an unsigned divide
// assumes: caller holds partial remainder and quotient registers
`timescale 1ns/1ps
module ssd_udiv_step #(
    parameter int W = 32
) (
    input  wire logic [W-1:0] rem_i,
    input  wire logic [W-1:0] quo_i,
    input  wire logic [W-1:0] dvs_i,
    output logic      [W-1:0] rem_o,
    output logic      [W-1:0] quo_o
);
    logic [W:0] trial;
    logic [W:0] shifted;

    always_comb begin
        shifted = {rem_i, quo_i[W-1]};
        trial   = shifted - {1'b0, dvs_i};
        if (trial[W]) begin
            rem_o = shifted[W-1:0];
            quo_o = {quo_i[W-2:0], 1'b0};
        end else begin
            rem_o = trial[W-1:0];
            quo_o = {quo_i[W-2:0], 1'b1};
        end
    end
endmodule : ssd_udiv_step

// >>> design/ssd_divider.sv
// ssd_divider: signed 32 by 32 divide short unit, one bit per cycle
// assumes: issue logic pulses start_i with operands, holds no other op until done_o
`timescale 1ns/1ps
module ssd_divider
#(
    parameter int W = ssd_pkg::SSD_W
) (
    input  wire logic              clk_sys_i,
    input  wire logic              rst_i,
    input  wire logic              start_i,
    input  wire logic              cr_update_i,
    input  wire logic              ov_enable_i,
    input  wire logic [W-1:0]      dividend_register_i,
    input  wire logic [W-1:0]      divisor_register_i,
    output logic                   busy_o,
    output logic                   done_o,
    output logic      [W-1:0]      dest_o,
    output logic      [W-1:0]      remainder_reg_o,
    output logic      [3:0]        condition_field_zero_o,
    output logic                   overflow_flag_o,
    output logic                   summary_overflow_o
);
    import ssd_pkg::*;

    // ----------------------------------------------------------------
    // operand capture
    // ----------------------------------------------------------------
    ssd_state_e            state_r;
    logic [W-1:0]          quo_r;
    logic [W-1:0]          rem_r;
    logic [W-1:0]          dvs_r;
    logic                  neg_q_r;
    logic                  neg_r_r;
    logic                  ovf_r;
    logic                  mn1_r;
    logic                  cr_en_r;
    logic                  ov_en_r;
    logic [SSD_CNT_W-1:0]  cnt_r;
    logic [W-1:0]          rem_nxt;
    logic [W-1:0]          quo_nxt;
    logic [W-1:0]          abs_a;
    logic [W-1:0]          abs_b;
    logic [W-1:0]          q_fin;
    logic [W-1:0]          r_fin;
    logic                  ovf_now;
    logic                  mn1_now;
    logic                  take;
    logic                  cf_lt_nxt;
    logic                  cf_gt_nxt;
    logic                  cf_eq_nxt;
    logic                  so_nxt;

    // signed operands, magnitudes for the unsigned core
    assign abs_a   = dividend_register_i[W-1] ? W'(-dividend_register_i) : dividend_register_i;
    assign abs_b   = divisor_register_i[W-1]  ? W'(-divisor_register_i)  : divisor_register_i;
    assign mn1_now = (dividend_register_i == SSD_MOST_NEG) &&
                     (divisor_register_i == SSD_MINUS1);
    assign ovf_now = (divisor_register_i == SSD_ZERO) || mn1_now;
    assign take    = (state_r == SSD_IDLE) && start_i;

    ssd_udiv_step #(
        .W (W)
    ) u_step (
        .rem_i (rem_r),
        .quo_i (quo_r),
        .dvs_i (dvs_r),
        .rem_o (rem_nxt),
        .quo_o (quo_nxt)
    );

    // ----------------------------------------------------------------
    // sequencer
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            state_r <= SSD_IDLE;
        end else begin
            case (state_r)
                SSD_IDLE: begin
                    if (start_i) begin
                        state_r <= SSD_RUN;
                    end
                end
                SSD_RUN: begin
                    if (cnt_r == 6'h01) begin
                        state_r <= SSD_FIN;
                    end
                end
                SSD_FIN: begin
                    state_r <= SSD_IDLE;
                end
                default: begin
                    state_r <= SSD_IDLE;
                end
            endcase
        end
    end

    // step counter: loaded on take, one restoring step per run cycle
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_r <= '0;
        end else if (take) begin
            cnt_r <= SSD_STEPS;
        end else if (state_r == SSD_RUN) begin
            cnt_r <= cnt_r - 6'h01;
        end
    end

    // ----------------------------------------------------------------
    // datapath
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            quo_r   <= '0;
            rem_r   <= '0;
            dvs_r   <= '0;
            neg_q_r <= 1'b0;
            neg_r_r <= 1'b0;
            ovf_r   <= 1'b0;
            mn1_r   <= 1'b0;
            cr_en_r <= 1'b0;
            ov_en_r <= 1'b0;
        end else if (take) begin
            quo_r   <= abs_a;
            rem_r   <= '0;
            dvs_r   <= abs_b;
            neg_q_r <= dividend_register_i[W-1] ^ divisor_register_i[W-1];
            neg_r_r <= dividend_register_i[W-1];
            ovf_r   <= ovf_now;
            mn1_r   <= mn1_now;
            cr_en_r <= cr_update_i;
            ov_en_r <= ov_enable_i;
        end else if (state_r == SSD_RUN) begin
            quo_r <= quo_nxt;
            rem_r <= rem_nxt;
        end
    end

    // sign fix: negating a zero magnitude stays zero, so zeros are positive
    assign q_fin = neg_q_r ? W'(-quo_r) : quo_r;
    assign r_fin = neg_r_r ? W'(-rem_r) : rem_r;

    // ----------------------------------------------------------------
    // results
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            dest_o          <= '0;
            remainder_reg_o <= '0;
            done_o          <= 1'b0;
            busy_o          <= 1'b0;
        end else begin
            done_o <= (state_r == SSD_FIN);
            busy_o <= (state_r == SSD_IDLE) ? start_i : (state_r != SSD_FIN);
            if (state_r == SSD_FIN) begin
                if (mn1_r) begin
                    dest_o          <= SSD_MOST_NEG;
                    remainder_reg_o <= SSD_ZERO;
                end else begin
                    // zero divisor gives core garbage, left as is
                    dest_o          <= q_fin;
                    remainder_reg_o <= r_fin;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // condition field
    // ----------------------------------------------------------------
    // most negative over minus one leaves a zero remainder: equal only
    always_comb begin
        cf_lt_nxt = 1'b0;
        cf_gt_nxt = 1'b0;
        cf_eq_nxt = 1'b1;
        if (!mn1_r) begin
            cf_lt_nxt = r_fin[W-1];
            cf_gt_nxt = !r_fin[W-1] && (r_fin != SSD_ZERO);
            cf_eq_nxt = (r_fin == SSD_ZERO);
        end
    end

    // summary overflow after this op, copied into the condition field
    assign so_nxt = summary_overflow_o | (ov_en_r & ovf_r);

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            condition_field_zero_o <= SSD_CF_RST;
        end else if (state_r == SSD_FIN && cr_en_r) begin
            condition_field_zero_o[SSD_CF_LT] <= cf_lt_nxt;
            condition_field_zero_o[SSD_CF_GT] <= cf_gt_nxt;
            condition_field_zero_o[SSD_CF_EQ] <= cf_eq_nxt;
            condition_field_zero_o[SSD_CF_SO] <= so_nxt;
        end
    end

    // ----------------------------------------------------------------
    // overflow flags
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            overflow_flag_o    <= 1'b0;
            summary_overflow_o <= 1'b0;
        end else if (state_r == SSD_FIN && ov_en_r) begin
            overflow_flag_o <= ovf_r;
            if (ovf_r) begin
                summary_overflow_o <= 1'b1;
            end
        end
    end
endmodule : ssd_divider

// >>> sim/ssd_divider_chk.sv
// ssd_divider_chk: port-level timing and hold checks for ssd_divider
// assumes: bound to every ssd_divider instance, one clock domain
`timescale 1ns/1ps
module ssd_divider_chk
    import ssd_pkg::*;
(
    input wire logic        clk_sys_i,
    input wire logic        rst_i,
    input wire logic        start_i,
    input wire logic        busy_o,
    input wire logic        done_o,
    input wire logic [31:0] dest_o,
    input wire logic [31:0] remainder_reg_o,
    input wire logic [3:0]  condition_field_zero_o,
    input wire logic        overflow_flag_o,
    input wire logic        summary_overflow_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    done_latency_a: assert property (start_i && !busy_o |-> ##34 done_o)
        else $error("done not 34 cycles after start");
    busy_run_a: assert property (start_i && !busy_o |=> busy_o [*8])
        else $error("busy not held after start");
    done_pulse_a: assert property (done_o |-> !busy_o ##1 !done_o)
        else $error("done not a single idle pulse");
    result_hold_a: assert property (!done_o |->
        $stable(dest_o) && $stable(remainder_reg_o))
        else $error("results moved without done");
    cf_hold_a: assert property (!done_o |-> $stable(condition_field_zero_o))
        else $error("condition field moved without done");
    ov_hold_a: assert property (!done_o |-> $stable(overflow_flag_o))
        else $error("overflow flag moved without done");
    so_sticky_a: assert property (summary_overflow_o |=> summary_overflow_o)
        else $error("summary overflow cleared");
    ov_sets_so_a: assert property (overflow_flag_o |-> summary_overflow_o)
        else $error("overflow without summary overflow");
    cover property (done_o && overflow_flag_o);
    cover property (done_o && condition_field_zero_o[SSD_CF_LT]);
    cover property (done_o ##1 start_i);
endmodule : ssd_divider_chk

bind ssd_divider ssd_divider_chk ssd_divider_chk_i (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
    .start_i(start_i), .busy_o(busy_o), .done_o(done_o), .dest_o(dest_o),
    .remainder_reg_o(remainder_reg_o), .condition_field_zero_o(condition_field_zero_o),
    .overflow_flag_o(overflow_flag_o), .summary_overflow_o(summary_overflow_o));

// >>> sim/ssd_issue_model.sv
// ssd_issue_model: issue logic that hands one divide at a time to the unit
// assumes: caller uses the issue task; the unit answers with busy and done
`timescale 1ns/1ps
module ssd_issue_model (
    input  wire logic        clk_sys_i,
    input  wire logic        busy_i,
    output logic             start_o     = 1'b0,
    output logic             cr_update_o = 1'b0,
    output logic             ov_enable_o = 1'b0,
    output logic      [31:0] dividend_o  = 32'h0000_0000,
    output logic      [31:0] divisor_o   = 32'h0000_0000
);
    // waits for idle, pulses start one cycle, then scrambles released operands
    task automatic issue(input logic [31:0] a, input logic [31:0] b, input logic d,
                         input logic o);
        @(posedge clk_sys_i);
        while (busy_i) @(posedge clk_sys_i);
        start_o <= 1'b1;
        dividend_o <= a;
        divisor_o <= b;
        cr_update_o <= d;
        ov_enable_o <= o;
        @(posedge clk_sys_i);
        start_o <= 1'b0;
        {dividend_o, divisor_o, cr_update_o, ov_enable_o} <= ~{a, b, d, o};
    endtask : issue
endmodule : ssd_issue_model

// >>> sim/signed_short_divider_test.sv
// signed_short_divider_test: self-checking bench for ssd_divider
// assumes: ssd_issue_model drives the unit, results checked on done
`timescale 1ns/1ps
module signed_short_divider_test;
    import ssd_pkg::*;
    typedef struct {logic [31:0] a, b, q, r; logic [3:0] cf; logic ov, so, qm, cm;} ssd_exp_s;
    logic clk_sys_i = 1'b0, rst_i = 1'b1, start_i, cr_update_i, ov_enable_i, busy_o, done_o;
    logic [31:0] dividend_register_i, divisor_register_i, dest_o, remainder_reg_o;
    logic [3:0] condition_field_zero_o;
    logic overflow_flag_o, summary_overflow_o, cf_known = 1'b1;
    logic [3:0] cf_e = 4'h0;
    logic ov_e = 1'b0, so_e = 1'b0;
    int err_total = 0, num_checks = 0, cyc = 0;
    ssd_exp_s q[$];
    ssd_exp_s e;
    always #5 clk_sys_i = ~clk_sys_i;
    ssd_divider ssd_divider_i (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .start_i(start_i),
        .cr_update_i(cr_update_i), .ov_enable_i(ov_enable_i),
        .dividend_register_i(dividend_register_i), .divisor_register_i(divisor_register_i),
        .busy_o(busy_o), .done_o(done_o), .dest_o(dest_o), .remainder_reg_o(remainder_reg_o),
        .condition_field_zero_o(condition_field_zero_o), .overflow_flag_o(overflow_flag_o),
        .summary_overflow_o(summary_overflow_o));
    ssd_issue_model ssd_issue_model_i (.clk_sys_i(clk_sys_i), .busy_i(busy_o),
        .start_o(start_i), .cr_update_o(cr_update_i), .ov_enable_o(ov_enable_i),
        .dividend_o(dividend_register_i), .divisor_o(divisor_register_i));
    // ----------------------------------------------------------------
    // checking
    // ----------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic test_done;
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : test_done
    // notes the expected result, then hands the divide to the issue model
    task automatic run(input logic [31:0] a, input logic [31:0] b, input logic d,
                       input logic o);
        logic z, v;
        z = (b == SSD_ZERO);
        v = z || (a == SSD_MOST_NEG && b == SSD_MINUS1);
        e.a = a;
        e.b = b;
        e.qm = !z;
        e.q = SSD_MOST_NEG;
        e.r = SSD_ZERO;
        if (!v) begin
            e.q = $signed(a) / $signed(b);
            e.r = $signed(a) % $signed(b);
        end
        if (o) ov_e = v;
        so_e = so_e | (o & v);
        if (d) cf_e = {$signed(e.r) < 0, $signed(e.r) > 0, e.r == SSD_ZERO, so_e};
        if (d) cf_known = !z;
        e.cf = cf_e;
        e.ov = ov_e;
        e.so = so_e;
        e.cm = cf_known;
        q.push_back(e);
        ssd_issue_model_i.issue(a, b, d, o);
    endtask : run
    always @(negedge clk_sys_i) begin
        if (done_o === 1'b1 && q.size() > 0) begin
            e = q.pop_front();
            if (e.qm) chk(dest_o, e.q);
            if (e.qm) chk(remainder_reg_o, e.r);
            if (e.qm) chk(e.b * dest_o + remainder_reg_o, e.a);
            if (e.cm) chk({28'h0, condition_field_zero_o}, {28'h0, e.cf});
            chk({31'h0, overflow_flag_o}, {31'h0, e.ov});
            chk({31'h0, summary_overflow_o}, {31'h0, e.so});
        end
    end
    always @(posedge clk_sys_i) begin
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            err_total++;
            test_done();
        end
    end
    // ----------------------------------------------------------------
    // tests
    // ----------------------------------------------------------------
    logic [31:0] ta[10] = '{32'h64, 32'hffffff9c, 32'h64, 32'hffffff9c, 32'h6, 32'h3,
        32'h8000_0000, 32'h1234, 32'h8000_0000, 32'h0};
    logic [31:0] tb[10] = '{32'h7, 32'h7, 32'hfffffff9, 32'hfffffff9, 32'h3, 32'hfffffffa,
        32'hffff_ffff, 32'h0, 32'h1, 32'h5};
    initial begin
        void'($urandom(32'h727853fe));
        repeat (4) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        for (int i = 0; i < 20; i++) begin
            run(ta[i % 10], tb[i % 10], i[0] ^ (i >= 10), i[1]);
        end
        $display("directed sign, zero and overflow cases done");
        for (int i = 0; i < 60; i++) begin
            run($urandom, $urandom >> (i % 31), i[0], i[1]);
        end
        $display("random operands done");
        wait (q.size() == 0);
        @(posedge clk_sys_i);
        test_done();
    end
endmodule : signed_short_divider_test
